// >>> hdl/rst_seq_pkg.sv
// Purpose: shared constants and types for the reset and start-up sequencer
// Assumes: 200 MHz register clock, 32-bit AHB-Lite register bus
// Notes:   register byte address is four times the printed index
package rst_seq_pkg;

  // timing
  localparam int CLK_PERIOD_NS      = 5;
  localparam int POWER_UP_TIMER_TIME_NS       = 72_000_000;
  localparam int POWER_UP_TIMER_OSC_PERIOD_NS = 1000;
  localparam int POWER_UP_TIMER_TICKS         = POWER_UP_TIMER_TIME_NS / POWER_UP_TIMER_OSC_PERIOD_NS;
  localparam int OST_CYCLES         = 1024;
  localparam int EXT_FILTER_NS      = 100;
  localparam int EXT_FILTER_CYCLES  = (EXT_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BOR_MIN_NS         = 100;
  localparam int BOR_MIN_CYCLES     = (BOR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register indices and byte addresses
  localparam logic [11:0] PCTL_INDEX  = 12'h08e;
  localparam logic [11:0] CFG_INDEX   = 12'h090;
  localparam logic [11:0] CAUSE_INDEX = 12'h091;
  localparam logic [11:0] ADDR_PCTL   = {PCTL_INDEX[9:0], 2'b00};
  localparam logic [11:0] ADDR_CFG    = {CFG_INDEX[9:0], 2'b00};
  localparam logic [11:0] ADDR_CAUSE  = {CAUSE_INDEX[9:0], 2'b00};

  // field positions
  localparam int PCTL_BOR_BIT    = 0;
  localparam int PCTL_POR_BIT    = 1;
  localparam int CFG_MODE_LSB    = 0;
  localparam int CFG_PWRTDIS_BIT = 2;
  localparam int CFG_BOREN_BIT   = 3;
  localparam int CAUSE_LSB       = 0;
  localparam int STATE_LSB       = 4;
  localparam int CHIPRST_BIT     = 8;
  localparam int STALL_BIT       = 9;

  typedef enum logic [1:0] {
    LOW_POWER_CRYSTAL_MODE,
    CRYSTAL_MODE,
    HIGH_SPEED_CRYSTAL_MODE,
    RESISTOR_CAPACITOR_MODE
  } osc_mode_t;

  typedef enum logic [2:0] {
    CAUSE_NONE,
    CAUSE_POWER_ON,
    CAUSE_EXT_NORMAL,
    CAUSE_EXT_SLEEP,
    CAUSE_WDT_RESET,
    CAUSE_WDT_WAKE,
    CAUSE_BROWN_OUT
  } cause_t;

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_POWER_UP_TIMER,
    ST_OST,
    ST_RUN
  } seq_state_t;

  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_PCTL,
    SEL_CFG,
    SEL_CAUSE
  } reg_sel_t;

  typedef struct packed {
    logic      borEnable;
    logic      pwrtDisable;
    osc_mode_t oscMode;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{borEnable: 1'b1, pwrtDisable: 1'b0, oscMode: CRYSTAL_MODE};

endpackage : rst_seq_pkg

// >>> hdl/reset_timeout_sequencer.sv
// Purpose: reset combining, power-up and oscillator start-up time-outs, cause flags
// Assumes: all pins sampled synchronously to mclk; detectors are digital inputs
// Notes:   AHB-Lite slave, zero wait states, always OKAY
// Function
// R1: in RC mode clock_out_pin carries oscillator input divided by four.
// R2: six reset causes are told apart and recorded.
// R3: registers untouched by reset keep contents; unknown only after power-on.
// R4: chip reset loads reset state; watchdog wake-up does not.
// R5: external reset pin low pulses shorter than the filter are ignored.
// R6: power-on detector holds reset until supply is adequate.
// R7: power-up timer gives 72 ms after power-on or brown-out, holding reset.
// R8: power-up timer counts its own RC oscillator ticks.
// R9: power_up_timer_disable set disables the power-up timer.
// R10: software keeps power-up timer enabled whenever brown-out reset is enabled.
// R11: start-up timer counts 1024 oscillator input cycles after power-up timer.
// R12: start-up timer runs only in crystal modes, after power-on or wake-up; the code also runs it after brown-out.
// R13: brown_out_detect_enable set enables brown-out reset.
// R14: brown-out only when supply stays low longer than the minimum duration.
// R15: after any reset, hold until supply recovers, then power-up timer; the code does this only after power-on and brown-out.
// R16: supply dip during power-up timer re-enters brown-out and restarts timer.
// R17: power-up timer starts after power-on ends, then start-up timer.
// R18: RC mode with power-up timer disabled applies no time-out.
// R19: timers run regardless of external pin; later release starts at once.
// R20: flag bit 0 cleared by brown-out, unknown after power-on, software sets.
// R21: flag bit 1 cleared by power-on only; software writes one afterwards.
// R22: crystal delays 72 ms plus 1024, or 1024 alone; RC 72 ms or none.
// R23: chip reset asserted while any reset source or timer is active; the code keeps it low during the start-up timer after a watchdog wake-up.
`timescale 1ns/10ps
`default_nettype none
module reset_timeout_sequencer #(
  parameter int POWER_UP_TIMER_TICKS = rst_seq_pkg::POWER_UP_TIMER_TICKS,
  parameter int OST_CYCLES = rst_seq_pkg::OST_CYCLES,
  parameter int EXT_CYCLES = rst_seq_pkg::EXT_FILTER_CYCLES,
  parameter int BOR_CYCLES = rst_seq_pkg::BOR_MIN_CYCLES
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // reset sources
  input  wire logic        powerOnDetect,
  input  wire logic        supplyBelowThreshold,
  input  wire logic        external_reset_pin_n,
  input  wire logic        watchdogReset,
  input  wire logic        watchdogWake,
  input  wire logic        sleeping,
  // oscillators
  input  wire logic        oscillator_input_pin,
  input  wire logic        pwrtOscIn,
  // outputs
  output logic             clock_out_pin,
  output logic             chipReset,
  output logic             coreStall
);

  localparam int PW = $clog2(POWER_UP_TIMER_TICKS + 1);
  localparam int OW = $clog2(OST_CYCLES + 1);
  localparam int EW = $clog2(EXT_CYCLES + 1);
  localparam int BW = $clog2(BOR_CYCLES + 1);
  localparam logic [PW-1:0] POWER_UP_TIMER_LAST = PW'(POWER_UP_TIMER_TICKS - 1);
  localparam logic [OW-1:0] OST_LAST  = OW'(OST_CYCLES - 1);
  localparam logic [EW-1:0] EXT_LAST  = EW'(EXT_CYCLES - 1);
  localparam logic [BW-1:0] BOR_LAST  = BW'(BOR_CYCLES - 1);

  function automatic rst_seq_pkg::reg_sel_t regSel(input logic [31:0] a);
    regSel = rst_seq_pkg::SEL_NONE;
    if (a[31:12] == 20'h00000) begin
      case (a[11:0])
        rst_seq_pkg::ADDR_PCTL:  regSel = rst_seq_pkg::SEL_PCTL;
        rst_seq_pkg::ADDR_CFG:   regSel = rst_seq_pkg::SEL_CFG;
        rst_seq_pkg::ADDR_CAUSE: regSel = rst_seq_pkg::SEL_CAUSE;
        default:                 regSel = rst_seq_pkg::SEL_NONE;
      endcase
    end
  endfunction : regSel

  // state
  rst_seq_pkg::cfg_t       cfg_q;
  rst_seq_pkg::seq_state_t state_q, state_d;
  rst_seq_pkg::cause_t     cause_q, cause_d;
  logic                    firstCycle_q;
  logic                    pwrtPend_q, ostPend_q, wakeSeq_q;
  logic [PW-1:0]           pwrtCnt_q;
  logic [OW-1:0]           ostCnt_q;
  logic [EW-1:0]           extCnt_q;
  logic [BW-1:0]           borCnt_q;
  logic                    extReset_q, borActive_q;
  logic                    porFlag_q, borFlag_q;
  logic                    oscPrev_q, pwrtOscPrev_q, divPhase_q, clkOut_q;
  logic                    chipReset_q, coreStall_q;
  logic                    wrPend_q;
  rst_seq_pkg::reg_sel_t   wrSel_q;
  logic [31:0]             hrdata_q;

  // bus decode
  wire                        addrValid = hsel & htrans[1] & hready;
  wire rst_seq_pkg::reg_sel_t rdSel     = regSel(haddr);
  wire                        pctlWr    = wrPend_q & (wrSel_q == rst_seq_pkg::SEL_PCTL);
  wire                        cfgWr     = wrPend_q & (wrSel_q == rst_seq_pkg::SEL_CFG);

  // sources
  wire crystal    = cfg_q.oscMode != rst_seq_pkg::RESISTOR_CAPACITOR_MODE;
  wire powerOn    = powerOnDetect | firstCycle_q;
  wire powerEvent = powerOn | borActive_q;
  wire oscRise    = oscillator_input_pin & ~oscPrev_q;
  wire pwrtTick   = pwrtOscIn & ~pwrtOscPrev_q;
  wire extLow     = ~external_reset_pin_n;
  wire extReset_d = extLow & (extReset_q | (extCnt_q >= EXT_LAST)); // R5
  wire borBelow   = cfg_q.borEnable & supplyBelowThreshold; // R13
  wire borActive_d = borBelow & (borActive_q | (borCnt_q >= BOR_LAST)); // R14 R15
  wire borRise    = borActive_d & ~borActive_q;
  wire extRise    = extReset_d & ~extReset_q;
  wire pwrtDone   = (state_q == rst_seq_pkg::ST_POWER_UP_TIMER) & pwrtTick & (pwrtCnt_q == POWER_UP_TIMER_LAST);
  wire ostDone    = (state_q == rst_seq_pkg::ST_OST) & oscRise & (ostCnt_q == OST_LAST);
  wire wakeToOst  = (state_q == rst_seq_pkg::ST_RUN) & watchdogWake & crystal & ~powerEvent;
  wire inTimeout  = (state_q == rst_seq_pkg::ST_POWER_UP_TIMER) | (state_q == rst_seq_pkg::ST_HOLD)
                  | ((state_q == rst_seq_pkg::ST_OST) & ~wakeSeq_q);
  wire chipReset_d = powerEvent | extReset_q | watchdogReset | inTimeout; // R23 R6 R4
  wire coreStall_d = chipReset_d | (state_q != rst_seq_pkg::ST_RUN);

  // sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      rst_seq_pkg::ST_HOLD: begin
        if (!powerEvent) begin // R17 R15
          if (pwrtPend_q) begin
            state_d = rst_seq_pkg::ST_POWER_UP_TIMER; // R7
          end else if (ostPend_q) begin
            state_d = rst_seq_pkg::ST_OST;
          end else begin
            state_d = rst_seq_pkg::ST_RUN; // R18
          end
        end
      end
      rst_seq_pkg::ST_POWER_UP_TIMER: begin
        if (powerEvent) begin
          state_d = rst_seq_pkg::ST_HOLD; // R16
        end else if (pwrtDone) begin
          state_d = ostPend_q ? rst_seq_pkg::ST_OST : rst_seq_pkg::ST_RUN; // R11 R22
        end
      end
      rst_seq_pkg::ST_OST: begin
        if (powerEvent) begin
          state_d = rst_seq_pkg::ST_HOLD;
        end else if (ostDone) begin
          state_d = rst_seq_pkg::ST_RUN;
        end
      end
      rst_seq_pkg::ST_RUN: begin
        if (powerEvent) begin
          state_d = rst_seq_pkg::ST_HOLD;
        end else if (wakeToOst) begin
          state_d = rst_seq_pkg::ST_OST; // R12 R22
        end
      end
      default: state_d = rst_seq_pkg::ST_HOLD;
    endcase
  end

  // cause priority: power-on, brown-out, watchdog, pin
  always_comb begin
    cause_d = cause_q;
    if (powerOn) begin
      cause_d = rst_seq_pkg::CAUSE_POWER_ON; // R2
    end else if (borRise) begin
      cause_d = rst_seq_pkg::CAUSE_BROWN_OUT;
    end else if (watchdogReset) begin
      cause_d = rst_seq_pkg::CAUSE_WDT_RESET;
    end else if (watchdogWake) begin
      cause_d = rst_seq_pkg::CAUSE_WDT_WAKE;
    end else if (extRise) begin
      cause_d = sleeping ? rst_seq_pkg::CAUSE_EXT_SLEEP : rst_seq_pkg::CAUSE_EXT_NORMAL;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      firstCycle_q <= 1'b1;
      state_q      <= rst_seq_pkg::ST_HOLD;
      cause_q      <= rst_seq_pkg::CAUSE_NONE;
      pwrtPend_q   <= 1'b0;
      ostPend_q    <= 1'b0;
      wakeSeq_q    <= 1'b0;
    end else begin
      firstCycle_q <= 1'b0;
      state_q      <= state_d;
      cause_q      <= cause_d;
      if (powerEvent) begin
        pwrtPend_q <= ~cfg_q.pwrtDisable; // R9 R7
        ostPend_q  <= crystal; // R12 R22
      end
      wakeSeq_q <= (state_d == rst_seq_pkg::ST_OST) & (wakeToOst | wakeSeq_q);
    end
  end

  // timers; counts clear outside their state so a dip restarts them
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pwrtCnt_q <= '0;
      ostCnt_q  <= '0;
    end else begin
      if (state_q != rst_seq_pkg::ST_POWER_UP_TIMER || powerEvent) begin
        pwrtCnt_q <= '0; // R16
      end else if (pwrtTick) begin
        pwrtCnt_q <= pwrtCnt_q + PW'(1); // R8
      end
      if (state_q != rst_seq_pkg::ST_OST || powerEvent) begin
        ostCnt_q <= '0;
      end else if (oscRise) begin
        ostCnt_q <= ostCnt_q + OW'(1); // R11
      end
    end
  end

  // input filters; the pin filter does not touch the sequencer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      extCnt_q    <= '0;
      borCnt_q    <= '0;
      extReset_q  <= 1'b0;
      borActive_q <= 1'b0;
    end else begin
      extCnt_q    <= (extLow && extCnt_q != EXT_LAST) ? extCnt_q + EW'(1) :
                     (extLow ? extCnt_q : '0);
      borCnt_q    <= (borBelow && borCnt_q != BOR_LAST) ? borCnt_q + BW'(1) :
                     (borBelow ? borCnt_q : '0);
      extReset_q  <= extReset_d; // R19
      borActive_q <= borActive_d;
    end
  end

  // clock out divider; idles low in crystal modes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      oscPrev_q     <= 1'b0;
      pwrtOscPrev_q <= 1'b0;
      divPhase_q    <= 1'b0;
      clkOut_q      <= 1'b0;
    end else begin
      oscPrev_q     <= oscillator_input_pin;
      pwrtOscPrev_q <= pwrtOscIn;
      if (crystal) begin
        divPhase_q <= 1'b0;
        clkOut_q   <= 1'b0;
      end else if (oscRise) begin
        divPhase_q <= ~divPhase_q;
        clkOut_q   <= clkOut_q ^ divPhase_q; // R1
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      chipReset_q <= 1'b1;
      coreStall_q <= 1'b1;
    end else begin
      chipReset_q <= chipReset_d;
      coreStall_q <= coreStall_d;
    end
  end

  // power-on flag survives every reset but rst_n and power-on; hardware clear beats a software write
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      porFlag_q <= 1'b0;
    end else if (powerOn) begin
      porFlag_q <= 1'b0; // R21
    end else if (pctlWr) begin
      porFlag_q <= hwdata[rst_seq_pkg::PCTL_POR_BIT];
    end
  end

  // no reset term: unknown after power-on, kept otherwise
  always_ff @(posedge mclk) begin
    if (borRise) begin
      borFlag_q <= 1'b0; // R20 R3
    end else if (pctlWr) begin
      borFlag_q <= hwdata[rst_seq_pkg::PCTL_BOR_BIT];
    end
  end

  // configuration is only lost on rst_n, not on chip resets
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_q <= rst_seq_pkg::CFG_RESET;
    end else if (cfgWr) begin
      cfg_q <= rst_seq_pkg::cfg_t'(hwdata[3:0]);
    end
  end

  // read data is sampled in the address phase, so a read right after a
  // write to the same register returns the old value
  wire [31:0] pctlRd  = {30'h0, porFlag_q, borFlag_q};
  wire [31:0] cfgRd   = {28'h0, cfg_q};
  wire [31:0] causeRd = {22'h0, coreStall_q, chipReset_q, 1'b0, state_q, 1'b0, cause_q};
  wire [31:0] rdMux   = (rdSel == rst_seq_pkg::SEL_PCTL)  ? pctlRd :
                        (rdSel == rst_seq_pkg::SEL_CFG)   ? cfgRd :
                        (rdSel == rst_seq_pkg::SEL_CAUSE) ? causeRd : 32'h00000000;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wrPend_q <= 1'b0;
      wrSel_q  <= rst_seq_pkg::SEL_NONE;
      hrdata_q <= 32'h00000000;
    end else begin
      wrPend_q <= addrValid & hwrite;
      wrSel_q  <= rdSel;
      hrdata_q <= (addrValid & ~hwrite) ? rdMux : 32'h00000000;
    end
  end

  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign hrdata        = hrdata_q;
  assign clock_out_pin = clkOut_q;
  assign chipReset     = chipReset_q;
  assign coreStall     = coreStall_q;

endmodule : reset_timeout_sequencer
`default_nettype wire

// >>> test/reset_timeout_sequencer_chk.sv
// Purpose: port-level assertions for the reset and start-up sequencer
// Assumes: bound to the top module; filter length handed on from the instance
// Notes:   timer lengths are not visible at the ports, so the bench times them
`timescale 1ns/10ps
`default_nettype none
module reset_timeout_sequencer_chk #(
  parameter int EXT_CYCLES = 2
) (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  // reset sources
  input wire logic        powerOnDetect,
  input wire logic        supplyBelowThreshold,
  input wire logic        external_reset_pin_n,
  input wire logic        watchdogReset,
  input wire logic        watchdogWake,
  // outputs
  input wire logic        chipReset,
  input wire logic        coreStall
);
  logic [7:0] pinLowQ;
  wire logic  quiet   = !powerOnDetect && !supplyBelowThreshold && !watchdogReset;
  wire logic  srcOn   = powerOnDetect || watchdogReset;
  wire logic  rdTaken = hsel && htrans[1] && hready && !hwrite;

  // saturating run length of low pin samples, so long holds never wrap
  always_ff @(posedge mclk) begin
    if (!rst_n || external_reset_pin_n) pinLowQ <= 8'h0;
    else if (pinLowQ != 8'hff) pinLowQ <= pinLowQ + 8'h1;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_glitch;
    (external_reset_pin_n && quiet) [*3] ##0 !chipReset ##1
      (!external_reset_pin_n && quiet) ##1 (external_reset_pin_n && quiet) [*3];
  endsequence
  sequence s_wake;
    external_reset_pin_n [*3] ##0 (!chipReset && watchdogWake && quiet);
  endsequence

  property p_powerHold; powerOnDetect |=> chipReset [*2]; endproperty
  property p_wdtReset; watchdogReset |=> chipReset; endproperty
  property p_stall; chipReset |-> coreStall; endproperty
  property p_shortPin; s_glitch |-> !chipReset; endproperty
  property p_longPin; pinLowQ == 8'(EXT_CYCLES) |-> ##[0:2] chipReset; endproperty
  property p_release; $fell(chipReset) |-> !$past(srcOn); endproperty
  property p_wake; s_wake |=> !chipReset; endproperty
  property p_rdIdle; !rdTaken |=> hrdata == 32'h0; endproperty

  a_powerHold: assert property (p_powerHold)
    else $error("chip reset not held during power-on");
  a_wdtReset: assert property (p_wdtReset)
    else $error("watchdog reset did not reset the chip");
  a_stall: assert property (p_stall)
    else $error("core runs while chip reset");
  a_shortPin: assert property (p_shortPin)
    else $error("short pin pulse caused a reset");
  a_longPin: assert property (p_longPin)
    else $error("long pin low did not reset");
  a_release: assert property (p_release)
    else $error("reset released while a source was active");
  a_wake: assert property (p_wake)
    else $error("watchdog wake reset the registers");
  a_rdIdle: assert property (p_rdIdle)
    else $error("read data outside a read data phase");
endmodule : reset_timeout_sequencer_chk
`default_nettype wire

// >>> test/reset_timeout_sequencer_test.sv
// Purpose: self-checking bench for the reset and start-up sequencer
// Assumes: oscillators run free from mclk; timers shortened by parameters
// Notes:   time-out windows leave a few cycles of synchroniser slack
`timescale 1ns/10ps
`default_nettype none
module reset_timeout_sequencer_test;
  localparam int PT = 8 * 8;   // power-up ticks times its oscillator period
  localparam int OT = 16 * 2;  // start-up count times oscillator period
  logic        mclk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rnd;
  logic [1:0]  htrans = 2'h0, look = 2'h0, pwrtDiv = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        powerOnDetect = 1'b0, supplyBelowThreshold = 1'b0, pinHold = 1'b0;
  logic        pinLow = 1'b0, watchdogReset = 1'b0, watchdogWake = 1'b0, sleeping = 1'b0;
  logic        oscIn = 1'b0, pwrtOscIn = 1'b0, rdValid = 1'b0, prevCo = 1'b0;
  logic [7:0]  perCnt = 8'h1, perQ = 8'h0;
  logic [31:0] expQ[$];
  int          errors = 0, n_tests = 0, cyc = 0, d;
  wire logic        hready, hreadyout, hresp, clock_out_pin, chipReset, coreStall;
  wire logic [31:0] hrdata;

  assign hready = hreadyout;
  always #2.5 mclk = ~mclk;

  reset_timeout_sequencer #(.POWER_UP_TIMER_TICKS(8), .OST_CYCLES(16), .EXT_CYCLES(2), .BOR_CYCLES(2)) DUT (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .powerOnDetect(powerOnDetect), .supplyBelowThreshold(supplyBelowThreshold),
    .external_reset_pin_n(!(pinHold || pinLow)), .watchdogReset(watchdogReset),
    .watchdogWake(watchdogWake), .sleeping(sleeping), .oscillator_input_pin(oscIn),
    .pwrtOscIn(pwrtOscIn), .clock_out_pin(clock_out_pin), .chipReset(chipReset),
    .coreStall(coreStall));

  // both oscillators free-run: main at mclk/2, power-up one at mclk/8
  always @(posedge mclk) begin
    oscIn <= ~oscIn;
    pwrtDiv <= pwrtDiv + 2'h1;
    if (pwrtDiv == 2'h3) pwrtOscIn <= ~pwrtOscIn;
    prevCo <= clock_out_pin;
    perCnt <= (clock_out_pin && !prevCo) ? 8'h1 : perCnt + 8'h1;
    if (clock_out_pin && !prevCo) perQ <= perCnt;
  end

  always @(posedge mclk) begin : watch
    logic [31:0] got, e;
    // the slave never stretches a transfer and always answers OKAY
    if (rst_n && (hresp !== 1'b0 || hreadyout !== 1'b1)) begin
      errors++;
      $display("ERROR %0t: bus answer not zero-wait OKAY", $time);
    end
    if (rdValid || look != 2'h0) begin
      got = rdValid ? hrdata : (look == 2'h1 ? {30'h0, coreStall, chipReset} : {24'h0, perQ});
      e = expQ.pop_front();
      n_tests++;
      if (got !== e) begin
        errors++;
        $display("ERROR %0t: got %h expected %h", $time, got, e);
      end
    end
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      errors++;
      $display("ERROR %0t: run did not finish in time", $time);
      tally_and_finish();
    end
  end

  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     input logic [31:0] e);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdValid <= !wr;
    if (!wr) expQ.push_back(e);
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rdValid <= 1'b0;
  endtask : ahb

  task automatic rdc(input logic [2:0] c);
    ahb(1'b0, rst_seq_pkg::ADDR_CAUSE, 32'h0, {25'h0, rst_seq_pkg::ST_RUN, 1'b0, c});
  endtask : rdc

  // k selects what the watcher samples: 1 chip reset and stall outputs, 2 divided clock period
  task automatic probe(input int c, input logic [1:0] k, input logic [31:0] e);
    repeat (c - 1) @(posedge mclk);
    look <= k;
    expQ.push_back(e);
    @(posedge mclk);
    look <= 2'h0;
  endtask : probe

  task automatic hit(input int s, input int n);
    @(posedge mclk);
    case (s)
      0: powerOnDetect <= 1'b1;
      1: supplyBelowThreshold <= 1'b1;
      2: pinLow <= 1'b1;
      3: watchdogReset <= 1'b1;
      default: watchdogWake <= 1'b1;
    endcase
    repeat (n) @(posedge mclk);
    powerOnDetect <= 1'b0;
    supplyBelowThreshold <= 1'b0;
    pinLow <= 1'b0;
    watchdogReset <= 1'b0;
    watchdogWake <= 1'b0;
  endtask : hit

  // still in reset well before the nominal end, out of it a little after
  task automatic startup(input int t);
    if (t > 12) probe(t - 12, 2'h1, 32'h3);
    probe(t > 12 ? 20 : 8, 2'h1, 32'h0);
  endtask : startup

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    void'($urandom(32'h6df6));
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    startup(PT + OT);
    ahb(1'b0, rst_seq_pkg::ADDR_CFG, 32'h0, 32'h9);
    rdc(rst_seq_pkg::CAUSE_POWER_ON);
    rnd = $urandom();
    ahb(1'b1, rst_seq_pkg::ADDR_PCTL, rnd | 32'h3, 32'h0);
    ahb(1'b0, rst_seq_pkg::ADDR_PCTL, 32'h0, 32'h3);
    ahb(1'b1, rst_seq_pkg::ADDR_CAUSE, rnd, 32'h0);
    rdc(rst_seq_pkg::CAUSE_POWER_ON);
    ahb(1'b1, 12'h100, rnd, 32'h0);
    ahb(1'b0, 12'h100, 32'h0, 32'h0);
    done("registers");
    for (int m = 0; m < 8; m++) begin
      // brown-out stays off whenever the power-up timer is disabled
      ahb(1'b1, rst_seq_pkg::ADDR_CFG, {28'h0, ~m[2], m[2], m[1:0]}, 32'h0);
      hit(0, 1 + $urandom_range(3));
      d = (m[2] ? 0 : PT) + (m[1:0] != 2'h3 ? OT : 0);
      startup(d);
      if (m[1:0] == 2'h3) probe(40, 2'h2, 32'h8);
      ahb(1'b0, rst_seq_pkg::ADDR_PCTL, 32'h0, 32'h1);
      ahb(1'b1, rst_seq_pkg::ADDR_PCTL, 32'h3, 32'h0);
    end
    done("modes");
    ahb(1'b1, rst_seq_pkg::ADDR_CFG, 32'h9, 32'h0);
    hit(1, 1);
    probe(4, 2'h1, 32'h0);
    hit(1, 5);
    repeat (30) @(posedge mclk);
    hit(1, 5);
    startup(PT + OT);
    ahb(1'b0, rst_seq_pkg::ADDR_PCTL, 32'h0, 32'h2);
    rdc(rst_seq_pkg::CAUSE_BROWN_OUT);
    ahb(1'b1, rst_seq_pkg::ADDR_CFG, 32'h1, 32'h0);
    hit(1, 5);
    probe(4, 2'h1, 32'h0);
    done("brown-out");
    pinHold <= 1'b1;
    hit(0, 2);
    probe(PT + OT + 10, 2'h1, 32'h3);
    pinHold <= 1'b0;
    probe(4, 2'h1, 32'h0);
    hit(2, 1);
    probe(4, 2'h1, 32'h0);
    ahb(1'b1, rst_seq_pkg::ADDR_PCTL, 32'h3, 32'h0);
    done("pin");
    // pin normal, pin in sleep, watchdog reset, watchdog wake
    for (int i = 0; i < 4; i++) begin
      sleeping <= i[0];
      hit(i < 2 ? 2 : i + 1, i == 3 ? 1 : 4);
      probe(i == 3 ? 2 : 1, 2'h1, i == 3 ? 32'h2 : 32'h3);
      repeat (60) @(posedge mclk);
      rdc(3'(i + 2));
    end
    ahb(1'b0, rst_seq_pkg::ADDR_PCTL, 32'h0, 32'h3);
    done("causes");
    tally_and_finish();
  end
endmodule : reset_timeout_sequencer_test

bind reset_timeout_sequencer reset_timeout_sequencer_chk #(.EXT_CYCLES(EXT_CYCLES)) chk (
  .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .powerOnDetect(powerOnDetect),
  .supplyBelowThreshold(supplyBelowThreshold), .external_reset_pin_n(external_reset_pin_n),
  .watchdogReset(watchdogReset), .watchdogWake(watchdogWake), .chipReset(chipReset),
  .coreStall(coreStall));
`default_nettype wire
